//--- design/cswm_pkg.sv
// package of constants, types and helpers for the clock switch and fail-safe monitor
package cswm_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned FRC_NOM_KHZ    = 8000;
   localparam int unsigned LOW_POWER_RC_OSC_NOM_KHZ   = 31;
   localparam int unsigned PLL_LOCK_NS    = 2000;
   localparam int unsigned PLL_LOCK_CYC   = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MON_START_US   = 2000;
   localparam int unsigned MON_START_CYC_DEF = MON_START_US * 1000 / CLK_PERIOD_NS;
   localparam int unsigned MON_MISS_TICKS_DEF = 4;
   // source codes
   localparam logic [2:0] SRC_FRC      = 3'h0;
   localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
   localparam logic [2:0] SRC_PRI      = 3'h2;
   localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
   localparam logic [2:0] SRC_SECONDARY_OSC     = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC     = 3'h5;
   localparam logic [2:0] SRC_FRC16    = 3'h6;
   localparam logic [2:0] SRC_FRC_DIV  = 3'h7;
   // oscillator classes, also gate indices
   localparam logic [1:0] CLS_FRC  = 2'h0;
   localparam logic [1:0] CLS_PRI  = 2'h1;
   localparam logic [1:0] CLS_SECONDARY_OSC = 2'h2;
   localparam logic [1:0] CLS_LOW_POWER_RC_OSC = 2'h3;
   // primary submodes
   localparam logic [1:0] PSUB_EC = 2'h0;
   localparam logic [1:0] PSUB_MS = 2'h1;
   localparam logic [1:0] PSUB_HS = 2'h2;
   localparam logic [1:0] MON_CFG_ON = 2'h0;
   // register map
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam int unsigned CTRL_NEW_SOURCE_SEL_LSB = 0;
   localparam int unsigned CTRL_LOCK_BIT = 7;
   localparam int unsigned CTRL_PSC_LSB  = 8;
   localparam int unsigned STAT_CURRENT_SOURCE_SEL_LSB = 0;
   localparam int unsigned STAT_CF_BIT   = 3;
   localparam int unsigned STAT_PLLLK_BIT = 4;
   localparam int unsigned STAT_BUSY_BIT = 5;
   localparam int unsigned STAT_MON_BIT  = 6;
   localparam int unsigned STAT_DLY_BIT  = 7;
   localparam int unsigned STAT_GATE_LSB = 8;
   localparam logic        RST_LOCK = 1'b1;
   localparam logic [2:0]  RST_PSC  = 3'h0;
   localparam logic [2:0]  RST_NEW_SOURCE_SEL = 3'h0;
   localparam logic [3:0]  RST_GATE = 4'h1;

   typedef enum logic [3:0] {
      SW_IDLE = 4'b0001,
      SW_WAIT = 4'b0010,
      SW_OFF  = 4'b0100,
      SW_ON   = 4'b1000
   } cswm_sw_state_t;

   function automatic logic [1:0] cswm_class(input logic [2:0] s);
      unique case (s)
         SRC_PRI, SRC_PRI_PLL: cswm_class = CLS_PRI;
         SRC_SECONDARY_OSC:             cswm_class = CLS_SECONDARY_OSC;
         SRC_LOW_POWER_RC_OSC:             cswm_class = CLS_LOW_POWER_RC_OSC;
         default:              cswm_class = CLS_FRC;
      endcase
   endfunction

   function automatic logic cswm_uses_pll(input logic [2:0] s);
      cswm_uses_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction
endpackage

//--- design/cswm_top.sv
// clock source switch, pll lock tracking and fail-safe clock monitor with ahb-lite registers
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module cswm_top
   import cswm_pkg::*;
#(
   parameter int unsigned MON_START_CYC  = MON_START_CYC_DEF,
   parameter int unsigned MON_MISS_TICKS = MON_MISS_TICKS_DEF
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        frc_clk_in,
   input  wire logic        prim_clk_in,
   input  wire logic        secondary_osc_clk_in,
   input  wire logic        low_power_rc_osc_clk_in,
   input  wire logic        ost_done,
   input  wire logic        powerup_timer_done,
   input  wire logic        wake_event,
   input  wire logic        sleep_mode,
   input  wire logic [1:0]  switch_monitor_cfg,
   input  wire logic [2:0]  osc_config_select,
   input  wire logic [1:0]  primary_submode_cfg,
   input  wire logic        wdt_enable,
   input  wire logic        regulator_disabled,
   input  wire logic        timer_secondary_osc_en,
   output logic             frc_osc_en,
   output logic             prim_osc_en,
   output logic             secondary_osc_osc_en,
   output logic             low_power_rc_osc_osc_en,
   output logic             pll_en,
   output logic             pll_input_valid,
   output logic             usb_clk_en,
   output logic [3:0]       clk_gate_en,
   output logic [2:0]       current_source_sel,
   output logic             clock_fail_trap
);
   // all inputs except sys_clk, rst_n and the ahb-lite bus pass two flops; the third stage only feeds edge detection
   localparam int unsigned SW = 18;
   logic [SW-1:0] s1_r, s2_r;
   logic [3:0]    clk_d_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r    <= '0;
         s2_r    <= '0;
         clk_d_r <= '0;
      end else begin
         s1_r    <= {low_power_rc_osc_clk_in, secondary_osc_clk_in, prim_clk_in, frc_clk_in, ost_done, powerup_timer_done,
                     wake_event, sleep_mode, switch_monitor_cfg, osc_config_select,
                     primary_submode_cfg, wdt_enable, regulator_disabled, timer_secondary_osc_en};
         s2_r    <= s1_r;
         clk_d_r <= s2_r[17:14];
      end
   end

   wire [3:0] clk_s      = s2_r[17:14];
   wire       ost_s      = s2_r[13];
   wire       powerup_timer_s     = s2_r[12];
   wire       wake_s     = s2_r[11];
   wire       sleep_s    = s2_r[10];
   wire [1:0] fcksm_s    = s2_r[9:8];
   wire [2:0] osc_config_select_s     = s2_r[7:5];
   wire [1:0] psub_s     = s2_r[4:3];
   wire       wdt_s      = s2_r[2];
   wire       regdis_s   = s2_r[1];
   wire       tmr_secondary_osc_s = s2_r[0];
   wire [3:0] clk_edge   = clk_s & ~clk_d_r;

   // configuration fuses are captured once, after the synchronisers have filled
   logic [1:0] init_cnt_r;
   logic       cfg_valid_r;
   logic [1:0] cfg_fcksm_r, cfg_psub_r;
   logic       cfg_regdis_r;
   logic       wake_d_r;
   logic       mon_go_r;
   wire        cfg_load = !cfg_valid_r && (init_cnt_r == 2'h2);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         init_cnt_r   <= '0;
         cfg_valid_r  <= 1'b0;
         cfg_fcksm_r  <= 2'h3;
         cfg_psub_r   <= PSUB_EC;
         cfg_regdis_r <= 1'b0;
         wake_d_r     <= 1'b0;
         mon_go_r     <= 1'b0;
      end else begin
         wake_d_r <= wake_s;
         mon_go_r <= cfg_load;
         if (!cfg_valid_r)
            init_cnt_r <= init_cnt_r + 2'h1;
         if (cfg_load) begin
            cfg_valid_r  <= 1'b1;
            cfg_fcksm_r  <= fcksm_s;
            cfg_psub_r   <= psub_s;
            cfg_regdis_r <= regdis_s;
         end
      end
   end

   wire sw_en      = cfg_valid_r && !cfg_fcksm_r[1];
   wire mon_cfg_en = cfg_valid_r && (cfg_fcksm_r == MON_CFG_ON);

   // register state
   logic [2:0]     new_source_sel_r, cur_r, tgt_r, psc_r;
   logic           lock_r, cf_r, pll_lock_r, tgt_seen_r;
   logic [3:0]     gate_r;
   cswm_sw_state_t st_r, st_nxt;

   // ahb-lite slave: zero wait states, always okay
   logic       wr_pend_r;
   logic [7:0] wr_addr_r;
   wire        ahb_go   = hsel && hready && htrans[1];
   wire        ahb_wr   = ahb_go && hwrite;
   wire        ahb_rd   = ahb_go && !hwrite;
   wire        ctrl_wr  = wr_pend_r && (wr_addr_r == ADDR_CTRL);
   wire        stat_wr  = wr_pend_r && (wr_addr_r == ADDR_STAT);
   wire        cf_clr   = stat_wr && hwdata[STAT_CF_BIT];
   wire [2:0]  new_source_sel_in  = hwdata[CTRL_NEW_SOURCE_SEL_LSB +: 3];
   // new_source_sel only moves while unlocked, switching allowed and no switch in flight
   wire        new_source_sel_wr  = ctrl_wr && !lock_r && sw_en && (st_r == SW_IDLE);
   wire        busy     = (st_r != SW_IDLE);
   logic       mon_run_r, dly_act_r;
   wire [31:0] ctrl_rd  = {21'h0, psc_r, lock_r, 4'h0, new_source_sel_r};
   wire [31:0] stat_rd  = {20'h0, gate_r, dly_act_r, mon_run_r, busy, pll_lock_r, cf_r, cur_r};
   wire [31:0] rd_mux   = (haddr[7:0] == ADDR_CTRL && haddr[31:8] == 24'h0) ? ctrl_rd :
                          (haddr[7:0] == ADDR_STAT && haddr[31:8] == 24'h0) ? stat_rd : 32'h0;
   wire        map_hit  = (haddr[31:8] == 24'h0);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= '0;
         hrdata    <= '0;
      end else begin
         wr_pend_r <= ahb_wr && map_hit;
         wr_addr_r <= haddr[7:0];
         if (ahb_rd)
            hrdata <= rd_mux;
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_r <= RST_LOCK;
         psc_r  <= RST_PSC;
         new_source_sel_r <= RST_NEW_SOURCE_SEL;
      end else begin
         if (ctrl_wr) begin
            lock_r <= hwdata[CTRL_LOCK_BIT];
            psc_r  <= hwdata[CTRL_PSC_LSB +: 3];
         end
         if (new_source_sel_wr)
            new_source_sel_r <= new_source_sel_in;
      end
   end

   // class and stability decode
   wire [1:0] cls_cur   = cswm_class(cur_r);
   wire [1:0] cls_tgt   = cswm_class(tgt_r);
   wire       redundant = (new_source_sel_in == cur_r);
   wire       sw_start  = new_source_sel_wr && !redundant;
   // pll modes wait for lock, other crystal submodes for the startup timer, the rest for a live edge
   wire       tgt_xtal  = (cls_tgt == CLS_PRI) && (cfg_psub_r != PSUB_EC);
   wire       tgt_ok    = cswm_uses_pll(tgt_r) ? pll_lock_r :
                          tgt_xtal ? ost_s : tgt_seen_r;
   wire       same_cls  = (cls_cur == cls_tgt);
   // during a switch, gates only change while their clock sits low so no runt pulse reaches the tree
   wire       old_low   = !clk_s[cls_cur];
   wire       new_low   = !clk_s[cls_tgt];
   logic      fail_p;

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         SW_IDLE: if (sw_start) st_nxt = SW_WAIT;
         // no timeout here: a dead source outside the pll modes leaves the switch pending forever
         SW_WAIT: if (tgt_ok) st_nxt = same_cls ? SW_ON : SW_OFF;
         SW_OFF:  if (old_low) st_nxt = SW_ON;
         SW_ON:   if (same_cls || new_low) st_nxt = SW_IDLE;
         default: st_nxt = SW_IDLE;
      endcase
      if (fail_p)
         st_nxt = SW_IDLE;
   end

   wire handover = (st_r == SW_ON) && (same_cls || new_low);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r       <= SW_IDLE;
         tgt_r      <= SRC_FRC;
         tgt_seen_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (sw_start) begin
            tgt_r      <= new_source_sel_in;
            tgt_seen_r <= 1'b0;
         end else if (clk_edge[cls_tgt]) begin
            tgt_seen_r <= 1'b1;
         end
      end
   end

   // current source and clock gates; failure forces fast rc at once since the old clock is dead
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_r  <= SRC_FRC;
         gate_r <= RST_GATE;
      end else if (fail_p) begin
         cur_r  <= SRC_FRC;
         gate_r <= 4'h1 << CLS_FRC;
      end else if (cfg_load) begin
         cur_r  <= osc_config_select_s;
         gate_r <= 4'h1 << cswm_class(osc_config_select_s);
      end else if (st_r == SW_OFF && old_low) begin
         gate_r[cls_cur] <= 1'b0;
      end else if (handover) begin
         cur_r           <= tgt_r;
         gate_r[cls_tgt] <= 1'b1;
      end
   end

   // pll lock flag: cleared at reset, while pll_en is low and whenever a switch to a pll source starts
   logic [15:0] pll_cnt_r;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_lock_r <= 1'b0;
         pll_cnt_r  <= '0;
      end else if (!pll_en || (sw_start && cswm_uses_pll(new_source_sel_in))) begin
         pll_lock_r <= 1'b0;
         pll_cnt_r  <= '0;
      end else if (!pll_lock_r) begin
         pll_cnt_r <= pll_cnt_r + 16'h1;
         if (pll_cnt_r == 16'(PLL_LOCK_CYC - 1))
            pll_lock_r <= 1'b1;
      end
   end

   // monitor: optional start delay, then count low-power rc ticks without a system clock edge
   logic [31:0] dly_cnt_r;
   logic [7:0]  miss_r;
   logic        dly_seen_r;
   // start one edge after capture, once the fuses and the source code are valid
   wire mon_start = cfg_valid_r && (mon_go_r || (wake_s && !wake_d_r));
   wire dly_mode  = (cls_cur == CLS_SECONDARY_OSC) ||
                    ((cls_cur == CLS_PRI) && (cfg_psub_r == PSUB_EC || cfg_psub_r == PSUB_HS));
   wire dly_need  = mon_cfg_en && dly_mode;
   wire mon_edge  = clk_edge[cls_cur];
   wire low_power_rc_osc_tick = clk_edge[CLS_LOW_POWER_RC_OSC];
   wire dly_end   = dly_act_r && (dly_cnt_r == 32'h1);
   assign fail_p  = mon_cfg_en && ((mon_run_r && miss_r == 8'(MON_MISS_TICKS)) ||
                    (dly_end && !dly_seen_r && !mon_edge));
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dly_act_r  <= 1'b0;
         dly_cnt_r  <= '0;
         dly_seen_r <= 1'b0;
         mon_run_r  <= 1'b0;
         miss_r     <= '0;
      end else if (mon_start) begin
         dly_act_r  <= dly_need;
         dly_cnt_r  <= MON_START_CYC;
         dly_seen_r <= 1'b0;
         mon_run_r  <= !dly_need && mon_cfg_en;
         miss_r     <= '0;
      end else if (fail_p) begin
         dly_act_r <= 1'b0;
         mon_run_r <= 1'b1; // keeps watching fast rc
         miss_r    <= '0;
      end else if (dly_act_r) begin
         dly_cnt_r <= dly_cnt_r - 32'h1;
         if (mon_edge)
            dly_seen_r <= 1'b1;
         if (dly_end) begin
            dly_act_r <= 1'b0;
            mon_run_r <= 1'b1;
         end
      end else if (mon_edge || handover || sleep_s) begin
         miss_r <= '0; // sleep stops the time base, so the miss count is cleared too
      end else if (mon_run_r && low_power_rc_osc_tick) begin
         miss_r <= miss_r + 8'h1;
      end
   end

   // clock_fail_flag: a new failure in the clearing cycle wins
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cf_r            <= 1'b0;
         clock_fail_trap <= 1'b0;
      end else begin
         cf_r            <= fail_p || (cf_r && !cf_clr);
         clock_fail_trap <= fail_p;
      end
   end

   // oscillator enables; old and new oscillators both stay on throughout a switch
   wire tgt_live = busy;
   assign frc_osc_en  = !powerup_timer_s || cls_cur == CLS_FRC || (tgt_live && cls_tgt == CLS_FRC);
   assign prim_osc_en = cls_cur == CLS_PRI || (tgt_live && cls_tgt == CLS_PRI);
   assign secondary_osc_osc_en = cls_cur == CLS_SECONDARY_OSC || (tgt_live && cls_tgt == CLS_SECONDARY_OSC) ||
                        tmr_secondary_osc_s;
   // watchdog keeps its time base across clock failures and switches
   assign low_power_rc_osc_osc_en = (!powerup_timer_s && cfg_regdis_r) || wdt_s || (mon_cfg_en && !sleep_s) ||
                        cls_cur == CLS_LOW_POWER_RC_OSC || (tgt_live && cls_tgt == CLS_LOW_POWER_RC_OSC);
   // postscaled rc multiplied by the pll gives the 16/32/64 MHz system clocks
   assign pll_en = cswm_uses_pll(cur_r) || (tgt_live && cswm_uses_pll(tgt_r));
   // only direct and divide-by-2 keep the pll input in range
   assign pll_input_valid = (psc_r == 3'h0) || (psc_r == 3'h1);
   assign usb_clk_en = (cur_r == SRC_FRC_PLL) && pll_lock_r && pll_input_valid;
   assign clk_gate_en        = gate_r;
   assign current_source_sel = cur_r;

   wire unused_ok = &{1'b0, hsize, haddr[1:0], FRC_NOM_KHZ[0], LOW_POWER_RC_OSC_NOM_KHZ[0]};
endmodule // cswm_top
`default_nettype wire

//--- dv/cswm_top_asserts.sv
// port checker for the clock switch and fail-safe monitor
`timescale 1ns/1ps
`default_nettype none
module cswm_top_asserts
   import cswm_pkg::*;
#(
   parameter int unsigned MON_START_CYC  = 50,
   parameter int unsigned MON_MISS_TICKS = 4
) (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic       sleep_mode,
   input wire logic [1:0] switch_monitor_cfg,
   input wire logic       low_power_rc_osc_osc_en,
   input wire logic       prim_osc_en,
   input wire logic       pll_en,
   input wire logic       usb_clk_en,
   input wire logic       pll_input_valid,
   input wire logic [3:0] clk_gate_en,
   input wire logic [2:0] current_source_sel,
   input wire logic       clock_fail_trap
);
   logic [3:0] up_cnt_r;
   logic [3:0] up_cnt_nxt;
   // settles at 8, well after fuse capture on the third edge
   assign up_cnt_nxt = (up_cnt_r == 4'h8) ? up_cnt_r : up_cnt_r + 4'h1;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_cnt_r <= 4'h0;
      end else begin
         up_cnt_r <= up_cnt_nxt;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_trap; clock_fail_trap; endsequence
   sequence s_fallback; ##[0:1] (current_source_sel == SRC_FRC && clk_gate_en == RST_GATE); endsequence
   property p_trap_pulse; s_trap |=> !clock_fail_trap; endproperty
   property p_trap_frc; s_trap |-> s_fallback; endproperty
   property p_usb; usb_clk_en |-> (current_source_sel == SRC_FRC_PLL) && pll_input_valid; endproperty
   property p_usb_lock; $rose(usb_clk_en) |-> $past(pll_en, 50); endproperty
   property p_pll_on; current_source_sel == SRC_FRC_PLL |-> pll_en; endproperty
   property p_prim_on; current_source_sel == SRC_PRI |-> prim_osc_en; endproperty
   property p_gate; $onehot0(clk_gate_en); endproperty
   property p_low_power_rc_osc;
      (up_cnt_r == 4'h8 && switch_monitor_cfg == MON_CFG_ON && !sleep_mode) |-> low_power_rc_osc_osc_en;
   endproperty
   property p_no_switch;
      (up_cnt_r == 4'h8 && switch_monitor_cfg[1]) |-> $stable(current_source_sel);
   endproperty
   a_trap_pulse: assert property (p_trap_pulse) else $error("trap wider than a cycle");
   a_trap_frc: assert property (p_trap_frc) else $error("no fallback to fast rc");
   a_usb: assert property (p_usb) else $error("usb clock outside rc pll mode");
   a_usb_lock: assert property (p_usb_lock) else $error("usb clock before lock");
   a_pll_on: assert property (p_pll_on) else $error("pll off while selected");
   a_prim_on: assert property (p_prim_on) else $error("primary off while selected");
   a_gate: assert property (p_gate) else $error("two clock gates open");
   a_low_power_rc_osc: assert property (p_low_power_rc_osc) else $error("low-power rc off under monitor");
   a_no_switch: assert property (p_no_switch) else $error("source moved with switching off");
endmodule // cswm_top_asserts
bind cswm_top cswm_top_asserts #(
   .MON_START_CYC (MON_START_CYC),
   .MON_MISS_TICKS(MON_MISS_TICKS)
) u_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .sleep_mode(sleep_mode),
   .switch_monitor_cfg(switch_monitor_cfg), .low_power_rc_osc_osc_en(low_power_rc_osc_osc_en),
   .prim_osc_en(prim_osc_en), .pll_en(pll_en), .usb_clk_en(usb_clk_en),
   .pll_input_valid(pll_input_valid), .clk_gate_en(clk_gate_en),
   .current_source_sel(current_source_sel), .clock_fail_trap(clock_fail_trap)
);
`default_nettype wire

//--- dv/tb.sv
// self-checking bench for the clock switch and fail-safe monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cswm_pkg::*;
   logic        sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, rd_ph = 0;
   logic [31:0] haddr = 0, hwdata = 0, rs = 32'h2a;
   logic [1:0]  htrans = 0, mon_cfg = 2'h0;
   logic        frc_clk_in = 0, prim_clk_in = 0, secondary_osc_clk_in = 0, low_power_rc_osc_clk_in = 0;
   logic        ost_done = 0, powerup_timer_done = 0, wake_event = 0, wdt_enable = 0;
   logic        reg_dis = 1, timer_secondary_osc_en = 0, prim_run = 0;
   logic [2:0]  osc_cfg = SRC_FRC;
   wire logic   hreadyout, hresp, frc_osc_en, prim_osc_en, secondary_osc_osc_en, low_power_rc_osc_osc_en;
   wire logic   pll_en, pll_input_valid, usb_clk_en, clock_fail_trap;
   wire logic [31:0] hrdata;
   wire logic [3:0]  clk_gate_en;
   wire logic [2:0]  current_source_sel;
   logic [31:0] exp_q[$], msk_q[$];
   int          fail_count = 0, n_tests = 0, trap_cnt = 0, i;
   cswm_top #(.MON_START_CYC(50), .MON_MISS_TICKS(4)) uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frc_clk_in(frc_clk_in),
      .prim_clk_in(prim_clk_in), .secondary_osc_clk_in(secondary_osc_clk_in), .low_power_rc_osc_clk_in(low_power_rc_osc_clk_in),
      .ost_done(ost_done), .powerup_timer_done(powerup_timer_done), .wake_event(wake_event),
      .sleep_mode(1'b0), .switch_monitor_cfg(mon_cfg), .osc_config_select(osc_cfg),
      .primary_submode_cfg(PSUB_HS), .wdt_enable(wdt_enable), .regulator_disabled(reg_dis),
      .timer_secondary_osc_en(timer_secondary_osc_en), .frc_osc_en(frc_osc_en), .prim_osc_en(prim_osc_en),
      .secondary_osc_osc_en(secondary_osc_osc_en), .low_power_rc_osc_osc_en(low_power_rc_osc_osc_en), .pll_en(pll_en),
      .pll_input_valid(pll_input_valid), .usb_clk_en(usb_clk_en), .clk_gate_en(clk_gate_en),
      .current_source_sel(current_source_sel), .clock_fail_trap(clock_fail_trap)
   );
   always #10 sys_clk = ~sys_clk;
   always #30 frc_clk_in = ~frc_clk_in;
   always #50 if (prim_run) prim_clk_in = ~prim_clk_in;
   always #400 low_power_rc_osc_clk_in = ~low_power_rc_osc_clk_in;
   always #7000 secondary_osc_clk_in = ~secondary_osc_clk_in;
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // the watchdog and timer enables wander at random: the monitor must not care
   always @(posedge sys_clk) begin
      rs = xs(rs);
      wdt_enable <= rs[0];
      timer_secondary_osc_en <= rs[1];
      if (clock_fail_trap === 1'b1) trap_cnt++;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
      n_tests++;
      if (seen !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, seen);
      end
   endtask
   task automatic chk_pin(input string nm, input logic seen, input logic e);
      chk(nm, {31'h0, seen}, {31'h0, e});
   endtask
   // read data is compared by the watcher in the data phase, oldest note first
   always @(posedge sys_clk) begin
      if (rd_ph) begin
         chk("hrdata", hrdata & msk_q.pop_front(), exp_q.pop_front());
         chk_pin("hresp", hresp, 1'b0);
      end
   end
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         tally_and_finish();
      end
   endtask
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= !w;
      wait_rdy();
      rd_ph <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(a, 1'b0, 32'h0);
   endtask
   task automatic wait_cur(input logic [2:0] e, input int lim);
      int n;
      n = 0;
      while (current_source_sel !== e && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      chk("current", {29'h0, current_source_sel}, {29'h0, e});
      if (current_source_sel !== e) tally_and_finish();
   endtask
   task automatic do_reset();
      rst_n <= 1'b0;
      powerup_timer_done <= 1'b0;
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge sys_clk);
      powerup_timer_done <= 1'b1;
   endtask
   initial begin
      #2000000;
      fail_count++;
      tally_and_finish();
   end
   initial begin
      do_reset();
      chk_pin("low_power_rc_osc_en", low_power_rc_osc_osc_en, 1'b1);
      wait_cur(SRC_FRC, 4);
      rd(ADDR_STAT, 32'h40, 32'hc0);
      wake_event <= 1'b1;
      for (i = 0; i < 4; i++) rd({rs[31:8] | 24'h1, 8'h04}, 32'h0, 32'hffffffff);
      wake_event <= 1'b0;
      rd(32'h8, 32'h0, 32'hffffffff);
      bus(ADDR_CTRL, 1'b1, 32'h81);
      repeat (30) @(posedge sys_clk);
      rd(ADDR_STAT, 32'h0, 32'h27);
      for (i = 0; i < 8; i++) begin
         bus(ADDR_CTRL, 1'b1, i << 8);
         @(negedge sys_clk);
         chk_pin("pll_in_ok", pll_input_valid, i < 2);
      end
      rd(ADDR_STAT, 32'h0, 32'h27);
      bus(ADDR_CTRL, 1'b1, {29'h0, SRC_FRC_PLL});
      wait_cur(SRC_FRC_PLL, 400);
      chk_pin("usb_en", usb_clk_en, 1'b1);
      rd(ADDR_STAT, 32'h11, 32'h1f);
      bus(ADDR_CTRL, 1'b1, {29'h0, SRC_FRC});
      wait_cur(SRC_FRC, 400);
      prim_run = 1'b1;
      bus(ADDR_CTRL, 1'b1, {29'h0, SRC_PRI});
      repeat (200) @(posedge sys_clk);
      rd(ADDR_STAT, 32'h20, 32'h3f);
      chk_pin("prim_en", prim_osc_en, 1'b1);
      ost_done <= 1'b1;
      wait_cur(SRC_PRI, 200);
      chk("gates", {28'h0, clk_gate_en}, 32'h2);
      chk_pin("frc_en", frc_osc_en, 1'b0);
      prim_run = 1'b0;
      wait_cur(SRC_FRC, 600);
      @(negedge sys_clk);
      chk("traps", trap_cnt, 32'h1);
      rd(ADDR_STAT, 32'h08, 32'h0f);
      bus(ADDR_STAT, 1'b1, 32'h8);
      rd(ADDR_STAT, 32'h0, 32'h08);
      mon_cfg <= 2'h2;
      osc_cfg <= SRC_LOW_POWER_RC_OSC;
      reg_dis <= 1'b0;
      do_reset();
      wait_cur(SRC_LOW_POWER_RC_OSC, 4);
      // unlock first, so that only the disabled switch can refuse the second write
      bus(ADDR_CTRL, 1'b1, 32'h0);
      bus(ADDR_CTRL, 1'b1, 32'h0);
      repeat (100) @(posedge sys_clk);
      wait_cur(SRC_LOW_POWER_RC_OSC, 1);
      chk_pin("low_power_rc_osc_en", low_power_rc_osc_osc_en, 1'b1);
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
